// File: core/sglc_config.sv
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
`include "sglc_defines.svh"

// Contract
// - 14-bit max length, reset 2000, truncates longer
// - max length accepts values up to 9000
// - 16-bit tag type, reset 0x9100, default/outer
// - shaper bit adds gap and preamble; reset 0
// - policer bit adds gap and preamble; reset 1
// - vlan master enable, reset zero
// - drop invalid vid, else to host; reset 1
// - unknown vid forwarding overrides drop bit
// - entry update loads 3-bit age count, reset 100
// - aging time from age count and period
// - reserved multicast table enable, reset zero
// - hash 00/11 uses ten low address bits
// - hash 01 crc (reset), 10 xor
module sglc_config
  import sglc_pkg::*;
#(
  parameter int ADDR_W = 12, // byte address width of the bus
  parameter int LEN_W = 14, // frame length width
  parameter int PERIOD_W = 8 // age period width
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // frame length path
  input wire logic [LEN_W-1:0] frame_len_in,
  output logic [LEN_W-1:0] frame_len_out,
  output logic frame_trunc,
  // tag type path
  input wire logic rx_tagged,
  input wire logic [15:0] rx_tag_type,
  output logic [15:0] ingress_tag_type,
  output logic [15:0] outer_tag_out,
  // credit accounting
  input wire logic [15:0] pkt_data_bytes,
  output logic [16:0] shaper_deduct,
  output logic [16:0] policer_deduct,
  // vlan filtering
  input wire logic vid_invalid,
  input wire logic unknown_vid_fwd_en,
  output logic vlan_mode_en,
  output logic vid_drop,
  output logic vid_to_host,
  // aging
  input wire logic dyn_entry_update,
  input wire logic [PERIOD_W-1:0] age_period,
  output logic [2:0] age_count_load,
  output logic age_count_load_valid,
  output logic [PERIOD_W+2:0] aging_time,
  // lookup
  output logic rsvd_mcast_en,
  input wire logic [47:0] dest_addr,
  output logic [9:0] lookup_index
);

  // ****************************************************
  // elaboration checks
  // ****************************************************
  // the length port width must match the length field, and the
  // top index must fit the bus address
  if (LEN_W != `SGLC_MFL_MSB + 1) begin : g_len_chk
    $error("frame length width must match the field");
  end
  if (ADDR_W < 12) begin : g_adr_chk
    $error("bus address too narrow for the register map");
  end
  if (PERIOD_W < 1) begin : g_per_chk
    $error("age period width must be positive");
  end

  // ****************************************************
  // functions
  // ****************************************************
  // decode the two-bit hash field into a mapping kind
  function automatic sglc_hash_e hash_kind(input logic [1:0] sel);
    sglc_hash_e k;
    k = sglc_hash_direct;
    case (sel)
      2'h1: k = sglc_hash_crc;
      2'h2: k = sglc_hash_xor;
      default: k = sglc_hash_direct;
    endcase
    return k;
  endfunction

  // serial crc over the address, msb first
  function automatic sglc_index_t crc10(input logic [47:0] a);
    logic [9:0] c;
    logic fb;
    c = 10'h3FF;
    fb = 1'b0;
    for (int i = 47; i >= 0; i--) begin
      fb = c[9] ^ a[i];
      c = {c[8:0], 1'b0};
      if (fb) begin
        c = c ^ `SGLC_CRC10_POLY;
      end
    end
    return c;
  endfunction

  // fold the address into ten bits by xor
  function automatic sglc_index_t xor10(input logic [47:0] a);
    logic [9:0] x;
    x = a[9:0] ^ a[19:10] ^ a[29:20] ^ a[39:30];
    x = x ^ {2'h0, a[47:40]};
    return x;
  endfunction

  // byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] din,
    input logic [3:0] sel
  );
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = din[7:0];
    end
    if (sel[1]) begin
      r[15:8] = din[15:8];
    end
    return r;
  endfunction

  // ****************************************************
  // registers
  // ****************************************************
  logic [15:0] max_frame_length; // bits 15:14 stored, unused
  logic [15:0] outer_tag_type; // default and outer tag type
  logic [1:0] shaper_credit_strategy; // only two live bits
  logic [7:0] lookup_engine_control_zero; // lookup control

  // ****************************************************
  // bus decode
  // ****************************************************
  logic [9:0] idx; // word index of the access
  logic req; // request present and not yet answered
  logic wr; // write strobe, taken with the ack
  logic hit_mfl;
  logic hit_tag;
  logic hit_cbs;
  logic hit_lec;
  logic [31:0] next_rdata; // read value for this index

  assign idx = wb_adr_i[11:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // the write lands at the edge where the master sees ack high, so a
  // cycle dropped before its ack leaves the registers untouched
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & clk_en;

  // address decode; unmapped indices read zero and drop writes
  always_comb begin
    hit_mfl = 1'b0;
    hit_tag = 1'b0;
    hit_cbs = 1'b0;
    hit_lec = 1'b0;
    next_rdata = 32'h0000_0000;
    if (idx == `SGLC_IDX_MAX_FRAME_LENGTH) begin
      hit_mfl = 1'b1;
      next_rdata = {16'h0000, max_frame_length};
    end else if (idx == `SGLC_IDX_OUTER_TAG_TYPE) begin
      hit_tag = 1'b1;
      next_rdata = {16'h0000, outer_tag_type};
    end else if (idx == `SGLC_IDX_SHAPER_CREDIT_STRATEGY) begin
      hit_cbs = 1'b1;
      // upper bits are read-only zero
      next_rdata = {30'h0000_0000, shaper_credit_strategy};
    end else if (idx == `SGLC_IDX_LOOKUP_ENGINE_CONTROL_ZERO) begin
      hit_lec = 1'b1;
      next_rdata = {24'h00_0000, lookup_engine_control_zero};
    end
  end

  // ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else if (clk_en) begin
      wb_ack_o <= req;
    end
  end

  // read data captured with the ack
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en && req) begin
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : next_rdata;
    end
  end

  // ****************************************************
  // register writes
  // ****************************************************
  // maximum frame length, any 14-bit value incl. jumbo
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      max_frame_length <= `SGLC_RST_MAX_FRAME_LENGTH;
    end else if (wr && hit_mfl) begin
      // no clamp: up to 9000 and beyond are kept as written
      max_frame_length <= merge16(max_frame_length, wb_dat_i, wb_sel_i);
    end
  end

  // tag protocol identifier
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      outer_tag_type <= `SGLC_RST_OUTER_TAG_TYPE;
    end else if (wr && hit_tag) begin
      outer_tag_type <= merge16(outer_tag_type, wb_dat_i, wb_sel_i);
    end
  end

  // credit accounting strategy, low lane only
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shaper_credit_strategy <= `SGLC_RST_SHAPER_CREDIT_STRATEGY;
    end else if (wr && hit_cbs && wb_sel_i[0]) begin
      shaper_credit_strategy <= wb_dat_i[1:0];
    end
  end

  // lookup engine control zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lookup_engine_control_zero <= `SGLC_RST_LOOKUP_ENGINE_CONTROL_ZERO;
    end else if (wr && hit_lec && wb_sel_i[0]) begin
      lookup_engine_control_zero <= wb_dat_i[7:0];
    end
  end

  // ****************************************************
  // field views
  // ****************************************************
  logic [LEN_W-1:0] mfl_lim; // live length limit
  logic shape_full; // shaper counts wire overhead
  logic police_full; // policer counts wire overhead
  logic vlan_en; // vlan master enable
  logic drop_inv; // drop invalid vid
  logic [2:0] age_cfg; // age count for updated entries
  logic [1:0] address_hash_select; // address_hash_select

  assign mfl_lim = max_frame_length[`SGLC_MFL_MSB:0];
  assign shape_full = shaper_credit_strategy[`SGLC_CBS_SHAPE_BIT];
  assign police_full = shaper_credit_strategy[`SGLC_CBS_POLICE_BIT];
  assign vlan_en = lookup_engine_control_zero[`SGLC_LEC_VLAN_EN_BIT];
  assign drop_inv = lookup_engine_control_zero[`SGLC_LEC_DROP_INV_BIT];
  assign age_cfg = lookup_engine_control_zero[`SGLC_LEC_AGE_MSB:`SGLC_LEC_AGE_LSB];
  assign address_hash_select =
    lookup_engine_control_zero[`SGLC_LEC_HASH_MSB:`SGLC_LEC_HASH_LSB];

  // ****************************************************
  // frame length truncation
  // ****************************************************
  // longer frames are cut to the limit, one cycle later
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frame_len_out <= '0;
      frame_trunc <= 1'b0;
    end else if (clk_en) begin
      if (frame_len_in > mfl_lim) begin
        frame_len_out <= mfl_lim;
        frame_trunc <= 1'b1;
      end else begin
        frame_len_out <= frame_len_in;
        frame_trunc <= 1'b0;
      end
    end
  end

  // ****************************************************
  // tag type selection
  // ****************************************************
  // untagged frames take the programmed type
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ingress_tag_type <= 16'h0000;
      outer_tag_out <= 16'h0000;
    end else if (clk_en) begin
      ingress_tag_type <= rx_tagged ? rx_tag_type : outer_tag_type;
      outer_tag_out <= outer_tag_type;
    end
  end

  // ****************************************************
  // credit deduction
  // ****************************************************
  // overhead is gap plus preamble, a fixed byte count
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shaper_deduct <= 17'h00000;
      policer_deduct <= 17'h00000;
    end else if (clk_en) begin
      if (shape_full) begin
        shaper_deduct <= {1'b0, pkt_data_bytes} + `SGLC_WIRE_OVERHEAD;
      end else begin
        shaper_deduct <= {1'b0, pkt_data_bytes};
      end
      if (police_full) begin
        policer_deduct <= {1'b0, pkt_data_bytes} + `SGLC_WIRE_OVERHEAD;
      end else begin
        policer_deduct <= {1'b0, pkt_data_bytes};
      end
    end
  end

  // ****************************************************
  // vlan filtering
  // ****************************************************
  // with vlan off nothing is judged; unknown-vid forwarding
  // outranks the drop bit and leaves the frame alone here
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vlan_mode_en <= 1'b0;
      vid_drop <= 1'b0;
      vid_to_host <= 1'b0;
    end else if (clk_en) begin
      vlan_mode_en <= vlan_en;
      vid_drop <= 1'b0;
      vid_to_host <= 1'b0;
      if (vlan_en && vid_invalid) begin
        if (unknown_vid_fwd_en) begin
          vid_drop <= 1'b0;
        end else if (drop_inv) begin
          vid_drop <= 1'b1;
        end else begin
          vid_to_host <= 1'b1;
        end
      end
    end
  end

  // ****************************************************
  // aging
  // ****************************************************
  // age count handed out with each dynamic entry update
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      age_count_load <= 3'h0;
      age_count_load_valid <= 1'b0;
    end else if (clk_en) begin
      age_count_load_valid <= dyn_entry_update;
      if (dyn_entry_update) begin
        age_count_load <= age_cfg;
      end
    end
  end

  // aging time is count times period
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aging_time <= '0;
    end else if (clk_en) begin
      aging_time <= (PERIOD_W+3)'(age_cfg * age_period);
    end
  end

  // ****************************************************
  // lookup mapping
  // ****************************************************
  // reserved multicast table enable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsvd_mcast_en <= 1'b0;
    end else if (clk_en) begin
      rsvd_mcast_en <= lookup_engine_control_zero[`SGLC_LEC_RSVD_MC_BIT];
    end
  end

  // index into the dynamic table by the selected hash
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lookup_index <= 10'h000;
    end else if (clk_en) begin
      case (hash_kind(address_hash_select))
        sglc_hash_crc: lookup_index <= crc10(dest_addr);
        sglc_hash_xor: lookup_index <= xor10(dest_addr);
        default: lookup_index <= dest_addr[9:0];
      endcase
    end
  end

endmodule // sglc_config

// File: core/sglc_defines.svh
`ifndef SGLC_DEFINES_SVH
`define SGLC_DEFINES_SVH

// ****************************************************
// register indices (byte address is four times these)
// ****************************************************
`define SGLC_IDX_MAX_FRAME_LENGTH 10'h308
`define SGLC_IDX_OUTER_TAG_TYPE 10'h30A
`define SGLC_IDX_SHAPER_CREDIT_STRATEGY 10'h30E
`define SGLC_IDX_LOOKUP_ENGINE_CONTROL_ZERO 10'h310

// ****************************************************
// reset values
// ****************************************************
`define SGLC_RST_MAX_FRAME_LENGTH 16'h07D0
`define SGLC_RST_OUTER_TAG_TYPE 16'h9100
`define SGLC_RST_SHAPER_CREDIT_STRATEGY 2'h1
`define SGLC_RST_LOOKUP_ENGINE_CONTROL_ZERO 8'h61

// ****************************************************
// field positions
// ****************************************************
`define SGLC_MFL_MSB 13
`define SGLC_CBS_SHAPE_BIT 1
`define SGLC_CBS_POLICE_BIT 0
`define SGLC_LEC_VLAN_EN_BIT 7
`define SGLC_LEC_DROP_INV_BIT 6
`define SGLC_LEC_AGE_MSB 5
`define SGLC_LEC_AGE_LSB 3
`define SGLC_LEC_RSVD_MC_BIT 2
`define SGLC_LEC_HASH_MSB 1
`define SGLC_LEC_HASH_LSB 0

// ****************************************************
// limits and counts
// ****************************************************
`define SGLC_JUMBO_MAX 16'h2328
`define SGLC_WIRE_OVERHEAD 17'h00014
`define SGLC_CRC10_POLY 10'h233

`endif

// File: core/sglc_pkg.sv
// ****************************************************
// shared types of the global lookup configuration
// ****************************************************
package sglc_pkg;

  // mapping used to place entries in the dynamic table
  typedef enum {
    sglc_hash_direct,
    sglc_hash_crc,
    sglc_hash_xor
  } sglc_hash_e;

  // decoded lookup index width
  typedef logic [9:0] sglc_index_t;

endpackage

// File: verification/sglc_config_checker.sv
`timescale 1ns/10ps
// *****
// port checks of the lookup configuration
// *****
module sglc_config_checker #(
  parameter int LEN_W = 14,
  parameter int PERIOD_W = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [LEN_W-1:0] frame_len_in,
  input wire logic [LEN_W-1:0] frame_len_out,
  input wire logic frame_trunc,
  input wire logic rx_tagged,
  input wire logic [15:0] rx_tag_type,
  input wire logic [15:0] ingress_tag_type,
  input wire logic [15:0] outer_tag_out,
  input wire logic [15:0] pkt_data_bytes,
  input wire logic [16:0] shaper_deduct,
  input wire logic [16:0] policer_deduct,
  input wire logic vid_invalid,
  input wire logic unknown_vid_fwd_en,
  input wire logic vlan_mode_en,
  input wire logic vid_drop,
  input wire logic vid_to_host,
  input wire logic dyn_entry_update,
  input wire logic age_count_load_valid,
  input wire logic [PERIOD_W-1:0] age_period,
  input wire logic [PERIOD_W+2:0] aging_time
);
  // high when the last edge was enabled and out of reset; outputs then follow inputs
  logic live;
  always_ff @(posedge clk_sys) begin
    live <= clk_en && !sys_rst;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_trunc_below: assert property (
    live && frame_trunc |-> frame_len_out < $past(frame_len_in))
    else $error("truncated length not below input");
  a_length_pass: assert property (
    live && !frame_trunc |-> frame_len_out == $past(frame_len_in))
    else $error("short frame length altered");
  a_tag_default: assert property (
    live && !$past(rx_tagged) |-> ingress_tag_type == outer_tag_out)
    else $error("untagged frame lacks default tag");
  a_tag_kept: assert property (
    live && $past(rx_tagged) |-> ingress_tag_type == $past(rx_tag_type))
    else $error("tagged frame type changed");
  a_shaper_sum: assert property (
    live |-> (shaper_deduct - {1'b0, $past(pkt_data_bytes)}) inside {17'h0, 17'h14})
    else $error("shaper deduction off");
  a_police_sum: assert property (
    live |-> (policer_deduct - {1'b0, $past(pkt_data_bytes)}) inside {17'h0, 17'h14})
    else $error("policer deduction off");
  a_vid_cause: assert property (
    live && (vid_drop || vid_to_host) |-> vlan_mode_en && $past(vid_invalid)
      && !$past(unknown_vid_fwd_en) && !(vid_drop && vid_to_host))
    else $error("vid verdict without cause");
  a_age_load: assert property (clk_en && dyn_entry_update |=> age_count_load_valid)
    else $error("entry update gave no age load");
  a_age_cause: assert property (live && age_count_load_valid |-> $past(dyn_entry_update))
    else $error("age load without update");
  a_age_zero: assert property (live && $past(age_period) == 0 |-> aging_time == 0)
    else $error("aging time not zero for zero period");
  a_ack_next: assert property (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_pulse: assert property (clk_en && wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
endmodule // sglc_config_checker
bind sglc_config sglc_config_checker #(.LEN_W(LEN_W), .PERIOD_W(PERIOD_W)) u_chk (.*);

// File: verification/switch_global_lookup_config_bench.sv
`timescale 1ns/10ps
`define CHECK(n, e, s) begin \
  comparisons++; \
  if ((s) !== (e)) begin \
    errors++; \
    $display("wrong value %s expected %h seen %h", n, e, s); \
  end \
end
// *****
// bench of the lookup configuration
// *****
module switch_global_lookup_config_bench;
  import sglc_pkg::*;
  // one write and the readback it should give
  typedef struct {logic [9:0] i; logic [31:0] d; logic [3:0] s; logic [15:0] e;} sglc_row_s;
  logic clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [13:0] frame_len_in = 14'h0, frame_len_out;
  logic frame_trunc, rx_tagged = 1'b0, vid_invalid = 1'b0, unknown_vid_fwd_en = 1'b0;
  logic [15:0] rx_tag_type = 16'h0, ingress_tag_type, outer_tag_out, pkt_data_bytes = 16'h0;
  logic [16:0] shaper_deduct, policer_deduct;
  logic vlan_mode_en, vid_drop, vid_to_host, dyn_entry_update = 1'b0, age_count_load_valid;
  logic [2:0] age_count_load;
  logic [7:0] age_period = 8'h0;
  logic [10:0] aging_time;
  logic rsvd_mcast_en;
  logic [47:0] dest_addr = 48'hA5C3_1F0E_9B27;
  logic [9:0] lookup_index;
  int errors = 0, comparisons = 0;
  // resets first (empty lanes), then lanes, read-only bits, an unmapped index
  sglc_row_s rows [12] = '{
    '{10'h308, 32'h0, 4'h0, 16'h07D0}, '{10'h30A, 32'h0, 4'h0, 16'h9100},
    '{10'h30E, 32'h0, 4'h0, 16'h0001}, '{10'h310, 32'h0, 4'h0, 16'h0061},
    '{10'h308, 32'h2328, 4'h3, 16'h2328}, '{10'h308, 32'hFFFF, 4'h1, 16'h23FF},
    '{10'h30A, 32'h88A8, 4'h3, 16'h88A8}, '{10'h30A, 32'hFFFF0000, 4'hC, 16'h88A8},
    '{10'h30E, 32'hFFFF, 4'h3, 16'h0003}, '{10'h30E, 32'h0, 4'h3, 16'h0000},
    '{10'h310, 32'hFF, 4'h1, 16'h00FF}, '{10'h3FF, 32'hFFFFFFFF, 4'hF, 16'h0000}
  };
  sglc_config dut (.*);
  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  // classic single cycle; waits for ack as long as it takes, the watchdog ends a hang
  task automatic wb(input logic we, input logic [9:0] i, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {i, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // let one edge land, then look
  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask
  // expected table index: direct, crc or xor mapping
  function automatic logic [9:0] hexp(input logic [1:0] h, input logic [47:0] a);
    logic [9:0] c;
    c = 10'h3FF;
    if (h == 2'b10) return a[9:0] ^ a[19:10] ^ a[29:20] ^ a[39:30] ^ {2'b00, a[47:40]};
    if (h != 2'b01) return a[9:0];
    for (int i = 47; i >= 0; i--) c = {c[8:0], 1'b0} ^ ((c[9] ^ a[i]) ? 10'h233 : 10'h000);
    return c;
  endfunction
  task automatic end_sim;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog, far beyond the expected run
  initial begin
    #1000000;
    errors++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (rows[k]) begin
      wb(1'b1, rows[k].i, rows[k].d, rows[k].s);
      wb(1'b0, rows[k].i, 32'h0, 4'hF);
      `CHECK("readback", {16'h0, rows[k].e}, q)
    end
    // limit at the jumbo size: below, equal, above
    wb(1'b1, 10'h308, 32'h2328, 4'h3);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      frame_len_in <= 14'h2327 + 14'(k);
      rx_tagged <= k[0];
      rx_tag_type <= 16'h8100;
      pkt_data_bytes <= 16'hFFFF;
      settle;
      `CHECK("length", (k == 2) ? 14'h2328 : 14'h2327 + 14'(k), frame_len_out)
      `CHECK("trunc", (k == 2), frame_trunc)
      `CHECK("tag", k[0] ? 16'h8100 : 16'h88A8, ingress_tag_type)
      `CHECK("outer", 16'h88A8, outer_tag_out)
    end
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 10'h30E, 32'(k), 4'h1);
      settle;
      `CHECK("shaper", 17'h0FFFF + (k[1] ? 17'h00014 : 17'h0), shaper_deduct)
      `CHECK("policer", 17'h0FFFF + (k[0] ? 17'h00014 : 17'h0), policer_deduct)
    end
    // every mix of enable, drop, invalid and unknown forwarding
    for (int k = 0; k < 16; k++) begin
      // no vlan table lives here; the enable is only set once it counts as filled
      wb(1'b1, 10'h310, {24'h0, k[0], k[1], 3'b100, k[0], 2'b01}, 4'h1);
      vid_invalid <= k[2];
      unknown_vid_fwd_en <= k[3];
      settle;
      `CHECK("vlan", k[0], vlan_mode_en)
      `CHECK("mcast", k[0], rsvd_mcast_en)
      `CHECK("drop", k[0] & k[2] & !k[3] & k[1], vid_drop)
      `CHECK("host", k[0] & k[2] & !k[3] & !k[1], vid_to_host)
    end
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, 10'h310, {26'h0, 3'(k), 3'b001}, 4'h1);
      dyn_entry_update <= 1'b1;
      age_period <= (k == 2) ? 8'h00 : 8'hFF;
      @(posedge clk_sys);
      dyn_entry_update <= 1'b0;
      #1;
      `CHECK("age", 3'(k), age_count_load)
      `CHECK("age valid", 1'b1, age_count_load_valid)
      `CHECK("age time", 11'(k) * 11'((k == 2) ? 0 : 255), aging_time)
      settle;
      `CHECK("age pulse", 1'b0, age_count_load_valid)
    end
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 10'h310, 32'(k), 4'h1);
      settle;
      `CHECK("index", hexp(2'(k), dest_addr), lookup_index)
    end
    // enable low must freeze the datapath
    @(posedge clk_sys);
    clk_en <= 1'b0;
    frame_len_in <= 14'h0005;
    settle;
    settle;
    `CHECK("frozen", 14'h2328, frame_len_out)
    @(posedge clk_sys);
    clk_en <= 1'b1;
    settle;
    `CHECK("resumed", 14'h0005, frame_len_out)
    // second reset in mid-run
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    wb(1'b0, 10'h308, 32'h0, 4'hF);
    `CHECK("reset length", 32'h07D0, q)
    wb(1'b0, 10'h310, 32'h0, 4'hF);
    `CHECK("reset control", 32'h61, q)
    settle;
    `CHECK("reset index", hexp(2'b01, dest_addr), lookup_index)
    `CHECK("reset vlan", 1'b0, vlan_mode_en)
    end_sim;
  end
endmodule // switch_global_lookup_config_bench
